// ### verilog/bvag_pkg.sv
`default_nettype none
package bvag_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_LOGIC_UNIT = 8'h00;
  localparam logic [7:0] OFS_PATTERN    = 8'h04;
  localparam logic [7:0] OFS_PAT_MULT   = 8'h08;
  localparam logic [7:0] OFS_CONTROL    = 8'h0c;
  localparam logic [7:0] OFS_SCROLL     = 8'h10;
  localparam logic [7:0] OFS_CONV_MODE  = 8'h14;
  localparam logic [7:0] OFS_READ_BUF   = 8'h18;
  localparam logic [7:0] OFS_HOST_CMD   = 8'h1c;
  localparam logic [7:0] OFS_STATUS     = 8'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LU_PLANE_CHOICE  = 0;
  localparam int LU_SINGLE_PLANE  = 1;
  localparam int CTL_SCROLL_EN    = 0;
  localparam int CTL_SECOND_ROM   = 1;
  localparam int ST_HANDSHAKE     = 0;
  localparam int ST_BLANK_N       = 1;
  localparam int ST_RMW           = 2;
  localparam int ST_GC_ACCESS     = 3;
  localparam int LP_ROM_SPACE_BIT = 15;
  localparam int LP_ROM_HALF_BIT  = 14;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [1:0]  LU_RESET      = 2'h0;
  localparam logic [1:0]  CTL_RESET     = 2'h0;
  localparam logic [7:0]  CONV_RESET    = 8'h00;
  localparam logic [1:0]  PLANES_IDLE_N = 2'h3;
  localparam logic [1:0]  PLANE0_WE_N   = 2'h2;
  localparam logic [1:0]  PLANE1_WE_N   = 2'h1;
  localparam logic [1:0]  PLANES_BOTH_N = 2'h0;
  localparam logic [1:0]  SEL_CONTROLLER = 2'h0;
  localparam logic [1:0]  SEL_OUTPUT_MAP = 2'h1;
  localparam logic [1:0]  SEL_CHAR_INIT  = 2'h2;

  // converter mode codes: hold, shift right, shift left, parallel load
  typedef enum logic [1:0] {
    CONV_HOLD  = 2'h0,
    CONV_RIGHT = 2'h1,
    CONV_LEFT  = 2'h2,
    CONV_LOAD  = 2'h3
  } bvag_conv_mode_t;

  // every pin input, gathered so one synchroniser covers them all
  typedef struct packed {
    logic        controller_blank;
    logic        row_col_byte_sel;
    logic        host_buf_rd_n;
    logic        host_wr_n;
    logic [7:0]  host_data;
    logic        gc_access;
    logic [15:0] gc_addr;
    logic        bm_wr_req;
    logic        rmw_cycle;
    logic        video_rd_n;
    logic [1:0]  video_sel;
    logic        lp_rd_n;
    logic        lp_io_m;
    logic [15:0] lp_addr;
    logic [31:0] plane_bytes;
  } bvag_pins_t;

endpackage
`default_nettype wire

// ### verilog/bvag_top.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - single-plane write hits plane zero if plane choice low, else plane one
// - row/column mux passes low byte when select low, high byte when high
// - host buffer read drives read buffer onto host bus and clears handshake
// - screen blank low is inverted controller blank, resynchronised to byte select
// - first ROM for low 16K or single 32K part, second ROM above 16K
// - 16-bit scroll counter runs while controller is off the bit map, supplies addresses when scroll enable high
// - four byte serialisers, one per plane and byte, each with own mode
// - local processor read strobe serves I/O and memory; I/O-or-memory line tells which
// - separate low read strobes for controller, output map, character counter init
// - vector pattern is pattern register bits, each held for multiplier+1 clocks
// - complementary read-modify-write qualifiers held through every such cycle
// - host data travels on an eight-bit two-way bus
// - serial input to local processor high while handshake flip-flop is set
// - latched address from controller when scroll enable low, counter when high
module bvag_top #(
  parameter int PAT_W    = 8,
  parameter int MULT_W   = 4,
  parameter int SCROLL_W = 16
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic                 pready,
  output var  logic [31:0]          prdata,
  output var  logic                 pslverr,
  input  wire bvag_pkg::bvag_pins_t pins,
  output var  logic [7:0]           host_data_bus_o,
  output var  logic                 host_data_bus_oe_n,
  output var  logic [7:0]           mem_addr,
  output var  logic [1:0]           plane_we_n,
  output var  logic                 screen_blank_n,
  output var  logic                 first_rom_enable_n,
  output var  logic                 second_rom_enable_n,
  output var  logic                 ram_enable_n,
  output var  logic                 controller_read_strobe_n,
  output var  logic                 output_map_read_strobe_n,
  output var  logic                 char_counter_init_strobe_n,
  output var  logic                 vector_pattern_n,
  output var  logic                 rmw_qualifier,
  output var  logic                 rmw_qualifier_n,
  output var  logic                 serial_in,
  output var  logic                 plane0_low_serial,
  output var  logic                 plane1_low_serial,
  output var  logic                 plane0_high_serial,
  output var  logic                 plane1_high_serial
);

  // refused at elaboration: the address mux and read-back word assume these bounds
  if (SCROLL_W != 16 || PAT_W < 2 || PAT_W > 32 || MULT_W < 1 || MULT_W > 31) begin
    $error("bvag_top: unsupported parameter values");
  end

  localparam int IDX_W = $clog2(PAT_W);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] conv_step(input logic [1:0] mode, input logic [7:0] sr,
                                           input logic [7:0] din);
    case (mode)
      bvag_pkg::CONV_RIGHT: conv_step = {1'b0, sr[7:1]};
      bvag_pkg::CONV_LEFT:  conv_step = {sr[6:0], 1'b0};
      bvag_pkg::CONV_LOAD:  conv_step = din;
      default:              conv_step = sr;
    endcase
  endfunction

  function automatic logic apb_hit(input logic [7:0] a, input logic [7:0] ofs);
    apb_hit = (a == ofs);
  endfunction

  // strobes are active low: a synchroniser reset to all zeros would show
  // a phantom host write and set the handshake right after reset
  function automatic bvag_pkg::bvag_pins_t pins_idle();
    pins_idle               = '0;
    pins_idle.host_buf_rd_n = 1'b1;
    pins_idle.host_wr_n     = 1'b1;
    pins_idle.video_rd_n    = 1'b1;
    pins_idle.lp_rd_n       = 1'b1;
  endfunction

  localparam bvag_pkg::bvag_pins_t PINS_IDLE = pins_idle();

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  bvag_pkg::bvag_pins_t pins_s1;
  bvag_pkg::bvag_pins_t pins_s2;
  logic                 rcbs_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1     <= PINS_IDLE;
      pins_s2     <= PINS_IDLE;
      rcbs_prev_r <= 1'b0;
    end else begin
      pins_s1     <= pins;
      pins_s2     <= pins_s1;
      rcbs_prev_r <= pins_s2.row_col_byte_sel;
    end
  end

  // ---------------------------------------------------------------
  // apb slave and registers
  // ---------------------------------------------------------------
  logic [1:0]        lu_r;
  logic [PAT_W-1:0]  pattern_r;
  logic [MULT_W-1:0] pat_mult_r;
  logic [1:0]        control_r;
  logic [7:0]        conv_mode_r;
  logic [7:0]        read_buf_r;
  logic [7:0]        host_cmd_r;
  logic              handshake_r;
  logic [15:0]       scroll_cnt_r;
  logic [7:0]        plane0_lo_r;
  logic [7:0]        plane1_lo_r;
  logic [7:0]        plane0_hi_r;
  logic [7:0]        plane1_hi_r;
  logic              apb_wr;
  logic              apb_rd;
  logic              mapped;
  logic [31:0]       rd_nxt;

  // pready rises in the first access cycle: one wait-free access phase
  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_nxt = '0;
    case (paddr)
      bvag_pkg::OFS_LOGIC_UNIT: rd_nxt[1:0]        = lu_r;
      bvag_pkg::OFS_PATTERN:    rd_nxt[PAT_W-1:0]  = pattern_r;
      bvag_pkg::OFS_PAT_MULT:   rd_nxt[MULT_W-1:0] = pat_mult_r;
      bvag_pkg::OFS_CONTROL:    rd_nxt[1:0]        = control_r;
      bvag_pkg::OFS_SCROLL:     rd_nxt[15:0]       = scroll_cnt_r;
      bvag_pkg::OFS_CONV_MODE:  rd_nxt[7:0]        = conv_mode_r;
      bvag_pkg::OFS_READ_BUF:   rd_nxt[7:0]        = read_buf_r;
      bvag_pkg::OFS_HOST_CMD:   rd_nxt[7:0]        = host_cmd_r;
      bvag_pkg::OFS_STATUS: begin
        rd_nxt[bvag_pkg::ST_HANDSHAKE] = handshake_r;
        rd_nxt[bvag_pkg::ST_BLANK_N]   = screen_blank_n;
        rd_nxt[bvag_pkg::ST_RMW]       = rmw_qualifier;
        rd_nxt[bvag_pkg::ST_GC_ACCESS] = pins_s2.gc_access;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (apb_rd) begin
        prdata <= rd_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lu_r        <= bvag_pkg::LU_RESET;
      pattern_r   <= '0;
      pat_mult_r  <= '0;
      control_r   <= bvag_pkg::CTL_RESET;
      conv_mode_r <= bvag_pkg::CONV_RESET;
      read_buf_r  <= '0;
    end else if (apb_wr) begin
      if (apb_hit(paddr, bvag_pkg::OFS_LOGIC_UNIT)) lu_r <= pwdata[1:0];
      if (apb_hit(paddr, bvag_pkg::OFS_PATTERN)) pattern_r <= pwdata[PAT_W-1:0];
      if (apb_hit(paddr, bvag_pkg::OFS_PAT_MULT)) pat_mult_r <= pwdata[MULT_W-1:0];
      if (apb_hit(paddr, bvag_pkg::OFS_CONTROL)) control_r <= pwdata[1:0];
      if (apb_hit(paddr, bvag_pkg::OFS_CONV_MODE)) conv_mode_r <= pwdata[7:0];
      if (apb_hit(paddr, bvag_pkg::OFS_READ_BUF)) read_buf_r <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // host handshake and data bus
  // ---------------------------------------------------------------
  logic host_rd_now;
  logic host_wr_now;
  assign host_rd_now = !pins_s2.host_buf_rd_n;
  assign host_wr_now = !pins_s2.host_wr_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      handshake_r <= 1'b0;
      host_cmd_r  <= '0;
    end else begin
      // read clears handshake; a host write in the same cycle wins
      if (host_wr_now) begin
        handshake_r <= 1'b1;
        host_cmd_r  <= pins_s2.host_data;
      end else if (host_rd_now) begin
        handshake_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data_bus_o    <= '0;
      host_data_bus_oe_n <= 1'b1;
      serial_in          <= 1'b0;
    end else begin
      host_data_bus_o    <= read_buf_r;
      host_data_bus_oe_n <= !host_rd_now;
      serial_in          <= handshake_r;
    end
  end

  // ---------------------------------------------------------------
  // bit-map addressing and plane writes
  // ---------------------------------------------------------------
  logic [15:0] lat_addr;
  logic [7:0]  lat_hi;
  logic [7:0]  lat_lo;
  logic        scroll_wr;

  assign lat_addr  = control_r[bvag_pkg::CTL_SCROLL_EN] ? scroll_cnt_r : pins_s2.gc_addr;
  assign lat_hi    = lat_addr[15:8];
  assign lat_lo    = lat_addr[7:0];
  assign scroll_wr = apb_wr && apb_hit(paddr, bvag_pkg::OFS_SCROLL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scroll_cnt_r <= '0;
    end else if (scroll_wr) begin
      scroll_cnt_r <= pwdata[15:0];
    end else if (!pins_s2.gc_access) begin
      // counter runs while controller is off the bit map
      scroll_cnt_r <= scroll_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr   <= '0;
      plane_we_n <= bvag_pkg::PLANES_IDLE_N;
    end else begin
      mem_addr <= pins_s2.row_col_byte_sel ? lat_hi : lat_lo;
      if (!pins_s2.bm_wr_req) begin
        plane_we_n <= bvag_pkg::PLANES_IDLE_N;
      end else if (!lu_r[bvag_pkg::LU_SINGLE_PLANE]) begin
        plane_we_n <= bvag_pkg::PLANES_BOTH_N;
      end else if (lu_r[bvag_pkg::LU_PLANE_CHOICE]) begin
        plane_we_n <= bvag_pkg::PLANE1_WE_N;
      end else begin
        plane_we_n <= bvag_pkg::PLANE0_WE_N;
      end
    end
  end

  // blank taken only on byte-select rise so it lines up with row timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      screen_blank_n <= 1'b1;
    end else if (pins_s2.row_col_byte_sel && !rcbs_prev_r) begin
      screen_blank_n <= !pins_s2.controller_blank;
    end
  end

  // ---------------------------------------------------------------
  // local processor memory and video access decode
  // ---------------------------------------------------------------
  logic lp_mem_rd;
  logic lp_rom;
  logic lp_upper;
  // memory reads are strobe low with the io/memory line low
  assign lp_mem_rd = !pins_s2.lp_rd_n && !pins_s2.lp_io_m;
  assign lp_rom    = !pins_s2.lp_addr[bvag_pkg::LP_ROM_SPACE_BIT];
  assign lp_upper  = pins_s2.lp_addr[bvag_pkg::LP_ROM_HALF_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_rom_enable_n  <= 1'b1;
      second_rom_enable_n <= 1'b1;
      ram_enable_n        <= 1'b1;
    end else begin
      // rom split at 16K when a second part is fitted
      first_rom_enable_n  <= !(lp_mem_rd && lp_rom &&
                               !(lp_upper && control_r[bvag_pkg::CTL_SECOND_ROM]));
      second_rom_enable_n <= !(lp_mem_rd && lp_rom && lp_upper &&
                               control_r[bvag_pkg::CTL_SECOND_ROM]);
      ram_enable_n        <= !(lp_mem_rd && !lp_rom);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controller_read_strobe_n   <= 1'b1;
      output_map_read_strobe_n   <= 1'b1;
      char_counter_init_strobe_n <= 1'b1;
    end else begin
      controller_read_strobe_n   <= !(!pins_s2.video_rd_n &&
                                      pins_s2.video_sel == bvag_pkg::SEL_CONTROLLER);
      output_map_read_strobe_n   <= !(!pins_s2.video_rd_n &&
                                      pins_s2.video_sel == bvag_pkg::SEL_OUTPUT_MAP);
      char_counter_init_strobe_n <= !(!pins_s2.video_rd_n &&
                                      pins_s2.video_sel == bvag_pkg::SEL_CHAR_INIT);
    end
  end

  // ---------------------------------------------------------------
  // pattern, read-modify-write, serialisers
  // ---------------------------------------------------------------
  logic [MULT_W-1:0] rep_cnt_r;
  logic [IDX_W-1:0]  pat_idx_r;

  // each bit stands for multiplier+1 clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_cnt_r        <= '0;
      pat_idx_r        <= '0;
      vector_pattern_n <= 1'b1;
    end else begin
      vector_pattern_n <= !pattern_r[pat_idx_r];
      if (rep_cnt_r >= pat_mult_r) begin
        rep_cnt_r <= '0;
        pat_idx_r <= (pat_idx_r == IDX_W'(PAT_W - 1)) ? '0 : pat_idx_r + 1'b1;
      end else begin
        rep_cnt_r <= rep_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rmw_qualifier   <= 1'b0;
      rmw_qualifier_n <= 1'b1;
    end else begin
      rmw_qualifier   <= pins_s2.rmw_cycle;
      rmw_qualifier_n <= !pins_s2.rmw_cycle;
    end
  end

  // four serialisers, two mode bits per converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plane0_lo_r        <= '0;
      plane1_lo_r        <= '0;
      plane0_hi_r        <= '0;
      plane1_hi_r        <= '0;
      plane0_low_serial  <= 1'b0;
      plane1_low_serial  <= 1'b0;
      plane0_high_serial <= 1'b0;
      plane1_high_serial <= 1'b0;
    end else begin
      plane0_lo_r        <= conv_step(conv_mode_r[1:0], plane0_lo_r, pins_s2.plane_bytes[7:0]);
      plane1_lo_r        <= conv_step(conv_mode_r[3:2], plane1_lo_r, pins_s2.plane_bytes[15:8]);
      plane0_hi_r        <= conv_step(conv_mode_r[5:4], plane0_hi_r, pins_s2.plane_bytes[23:16]);
      plane1_hi_r        <= conv_step(conv_mode_r[7:6], plane1_hi_r, pins_s2.plane_bytes[31:24]);
      // shift-left converters present the top bit, all others the bottom bit
      plane0_low_serial  <= (conv_mode_r[1:0] == bvag_pkg::CONV_LEFT) ? plane0_lo_r[7] : plane0_lo_r[0];
      plane1_low_serial  <= (conv_mode_r[3:2] == bvag_pkg::CONV_LEFT) ? plane1_lo_r[7] : plane1_lo_r[0];
      plane0_high_serial <= (conv_mode_r[5:4] == bvag_pkg::CONV_LEFT) ? plane0_hi_r[7] : plane0_hi_r[0];
      plane1_high_serial <= (conv_mode_r[7:6] == bvag_pkg::CONV_LEFT) ? plane1_hi_r[7] : plane1_hi_r[0];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_PLANE_ZERO: assert property (
    pins_s2.bm_wr_req && lu_r == 2'h2 |=> plane_we_n == 2'h2)
    else $error("single-plane write missed plane zero");
  AST_PLANE_ONE: assert property (
    pins_s2.bm_wr_req && lu_r == 2'h3 |=> plane_we_n == 2'h1)
    else $error("single-plane write missed plane one");
  AST_ROW_COL: assert property (
    ##1 mem_addr == ($past(pins_s2.row_col_byte_sel) ? $past(lat_hi) : $past(lat_lo)))
    else $error("row/column byte mux wrong");
  AST_BUF_READ: assert property (
    host_rd_now && !host_wr_now |=> !handshake_r && !host_data_bus_oe_n
    && host_data_bus_o == $past(read_buf_r))
    else $error("buffer read did not drive bus or clear flag");
  AST_BLANK: assert property (
    pins_s2.row_col_byte_sel && !rcbs_prev_r |=> screen_blank_n == !$past(pins_s2.controller_blank))
    else $error("screen blank not inverted at byte select");
  AST_BLANK_HOLD: assert property (
    !(pins_s2.row_col_byte_sel && !rcbs_prev_r) |=> $stable(screen_blank_n))
    else $error("screen blank moved off byte select");
  AST_ROM_LOW: assert property (
    lp_mem_rd && lp_rom && !lp_upper |=> !first_rom_enable_n && second_rom_enable_n)
    else $error("low rom space not on first rom");
  AST_ROM_HIGH: assert property (
    lp_mem_rd && lp_rom && lp_upper && control_r[1] |=> first_rom_enable_n && !second_rom_enable_n)
    else $error("upper rom space not on second rom");
  AST_SCROLL_RUN: assert property (
    presetn && !pins_s2.gc_access && !scroll_wr
    |=> scroll_cnt_r == $past(scroll_cnt_r) + 16'h0001)
    else $error("scroll counter did not advance");
  AST_CONV_LOAD: assert property (
    conv_mode_r[1:0] == 2'h3 |=> plane0_lo_r == $past(pins_s2.plane_bytes[7:0]))
    else $error("plane zero low converter did not load");
  AST_CTRL_STROBE: assert property (
    !pins_s2.video_rd_n && pins_s2.video_sel == 2'h0 |=> !controller_read_strobe_n
    && output_map_read_strobe_n && char_counter_init_strobe_n)
    else $error("controller read strobe wrong");
  AST_RMW_PAIR: assert property (
    pins_s2.rmw_cycle [*2] |=> rmw_qualifier && !rmw_qualifier_n)
    else $error("rmw qualifiers not held");
  AST_SERIAL_IN: assert property (
    handshake_r |=> serial_in)
    else $error("serial input low while flag set");
  AST_LATCH_SRC: assert property (
    control_r[0] |-> lat_addr == scroll_cnt_r)
    else $error("latched address not from scroll counter");

  CV_SINGLE_PLANE: cover property (pins_s2.bm_wr_req && lu_r[1] ##1 plane_we_n != 2'h3);
  CV_BUF_READ: cover property (handshake_r ##1 host_rd_now ##1 !handshake_r);
  CV_SECOND_ROM: cover property (!second_rom_enable_n);
  CV_BLANK: cover property (!screen_blank_n ##[1:50] screen_blank_n);

endmodule
`default_nettype wire

// ### tb/bvag_far_side.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------
// far side: host and local processor
// ------------------------------------
module bvag_far_side (
  input  wire logic                 pclk,
  input  wire logic [7:0]           host_data_bus_o,
  input  wire logic                 host_data_bus_oe_n,
  output var  bvag_pkg::bvag_pins_t pins
);
  bvag_pkg::bvag_pins_t drv_r;
  logic                 host_drv_r = 1'b0;
  logic [7:0]           last_r = 8'h00;
  always_comb begin
    pins = drv_r;
    if (!host_data_bus_oe_n)
      pins.host_data = host_data_bus_o;
    else if (!host_drv_r)
      pins.host_data = ~last_r;
  end
  // a floating bus moves every cycle so a stale byte never passes
  always_ff @(posedge pclk) last_r <= pins.host_data;
  task automatic drive(input bvag_pkg::bvag_pins_t v, input logic hd);
    @(posedge pclk);
    drv_r <= v;
    host_drv_r <= hd;
  endtask
endmodule
`default_nettype wire

// ### tb/bitmap_video_access_glue_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module bitmap_video_access_glue_tb_top;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, slv, last_pat;
  logic [7:0]           paddr, host_data_bus_o, mem_addr;
  logic [31:0]          pwdata, prdata, rd;
  logic [1:0]           plane_we_n;
  logic                 host_data_bus_oe_n, screen_blank_n, first_rom_enable_n, ram_enable_n;
  logic                 second_rom_enable_n, controller_read_strobe_n, serial_in;
  logic                 output_map_read_strobe_n, char_counter_init_strobe_n;
  logic                 vector_pattern_n, rmw_qualifier, rmw_qualifier_n, plane0_low_serial;
  logic                 plane1_low_serial, plane0_high_serial, plane1_high_serial;
  bvag_pkg::bvag_pins_t pins, p;
  int                   n_errors = 0, n_checks = 0, k, n_fall;
  logic [15:0]          la [5] = '{16'h0000, 16'h4000, 16'h8000, 16'h4000, 16'h0000};
  logic [2:0]           le [5] = '{3'h3, 3'h5, 3'h6, 3'h3, 3'h7};
  bvag_top u_bvag_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pins, .host_data_bus_o, .host_data_bus_oe_n, .mem_addr, .plane_we_n,
    .screen_blank_n, .first_rom_enable_n, .second_rom_enable_n, .ram_enable_n,
    .controller_read_strobe_n, .output_map_read_strobe_n, .char_counter_init_strobe_n,
    .vector_pattern_n, .rmw_qualifier, .rmw_qualifier_n, .serial_in, .plane0_low_serial,
    .plane1_low_serial, .plane0_high_serial, .plane1_high_serial);
  bvag_far_side u_bvag_far_side (.pclk, .host_data_bus_o, .host_data_bus_oe_n, .pins);
  // ------------------
  // bus and check tasks
  // ------------------
  task automatic test_done;
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20) begin
      n_errors++;
      test_done();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // a hung handshake still ends in the verdict
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    p = '0;
    {p.host_buf_rd_n, p.host_wr_n, p.video_rd_n, p.lp_rd_n} = 4'hf;
    u_bvag_far_side.drv_r = p;
    w(5);
    presetn <= 1'b1;
    apb(1'b0, bvag_pkg::OFS_LOGIC_UNIT, 32'h0);
    chk("logic_unit", 32'h0, rd);
    apb(1'b1, bvag_pkg::OFS_LOGIC_UNIT, 32'h3);
    {p.bm_wr_req, p.rmw_cycle} = 2'h3;
    u_bvag_far_side.drive(p, 1'b0);
    w(4);
    chk("plane_we_n", bvag_pkg::PLANE1_WE_N, plane_we_n);
    chk("rmw", 32'h2, {rmw_qualifier, rmw_qualifier_n});
    apb(1'b1, bvag_pkg::OFS_LOGIC_UNIT, 32'h2);
    w(3);
    chk("plane_we_n", bvag_pkg::PLANE0_WE_N, plane_we_n);
    chk("rmw", 32'h2, {rmw_qualifier, rmw_qualifier_n});
    apb(1'b0, bvag_pkg::OFS_LOGIC_UNIT, 32'h0);
    chk("logic_unit", 32'h2, rd);
    {p.bm_wr_req, p.rmw_cycle, p.gc_access, p.controller_blank} = 4'h3;
    p.gc_addr = 16'hab12;
    u_bvag_far_side.drive(p, 1'b0);
    w(4);
    chk("mem_addr", 32'h12, mem_addr);
    chk("plane_we_n", bvag_pkg::PLANES_IDLE_N, plane_we_n);
    chk("rmw", 32'h1, {rmw_qualifier, rmw_qualifier_n});
    p.row_col_byte_sel = 1'b1;
    u_bvag_far_side.drive(p, 1'b0);
    w(4);
    chk("mem_addr", 32'hab, mem_addr);
    chk("screen_blank_n", 32'h0, screen_blank_n);
    apb(1'b1, bvag_pkg::OFS_SCROLL, 32'h34cd);
    apb(1'b1, bvag_pkg::OFS_CONTROL, 32'h1);
    w(3);
    chk("mem_addr", 32'h34, mem_addr);
    apb(1'b1, bvag_pkg::OFS_READ_BUF, 32'h5a);
    {p.host_data, p.host_wr_n} = 9'h186;
    u_bvag_far_side.drive(p, 1'b1);
    w(5);
    chk("serial_in", 32'h1, serial_in);
    apb(1'b0, bvag_pkg::OFS_HOST_CMD, 32'h0);
    chk("host_cmd", 32'hc3, rd);
    p.host_wr_n = 1'b1;
    u_bvag_far_side.drive(p, 1'b1);
    p.host_buf_rd_n = 1'b0;
    u_bvag_far_side.drive(p, 1'b0);
    w(4);
    chk("host_bus", 32'h5a, {host_data_bus_oe_n, host_data_bus_o});
    w(1);
    chk("serial_in", 32'h0, serial_in);
    {p.host_buf_rd_n, p.lp_rd_n} = 2'h2;
    apb(1'b1, bvag_pkg::OFS_CONTROL, 32'h2);
    for (k = 0; k < 5; k++) begin
      if (k == 3)
        apb(1'b1, bvag_pkg::OFS_CONTROL, 32'h0);
      p.lp_io_m = (k == 4);
      p.lp_addr = la[k];
      u_bvag_far_side.drive(p, 1'b0);
      w(4);
      chk("mem_enable_n", le[k], {first_rom_enable_n, second_rom_enable_n, ram_enable_n});
    end
    {p.lp_rd_n, p.video_rd_n} = 2'h2;
    for (k = 0; k < 4; k++) begin
      p.video_sel = k[1:0];
      u_bvag_far_side.drive(p, 1'b0);
      w(4);
      chk("read_strobes_n", ~(32'h1 << k) & 32'h7, {char_counter_init_strobe_n,
        output_map_read_strobe_n, controller_read_strobe_n});
    end
    apb(1'b1, bvag_pkg::OFS_PATTERN, 32'h05);
    apb(1'b1, bvag_pkg::OFS_PAT_MULT, 32'h2);
    w(4);
    n_fall = 0;
    last_pat = vector_pattern_n;
    for (k = 0; k < 48; k++) begin
      @(posedge pclk);
      n_fall += (vector_pattern_n === 1'b0 && last_pat === 1'b1);
      last_pat = vector_pattern_n;
    end
    chk("pattern_falls", 32'h4, n_fall);
    p.plane_bytes = 32'h00ff00ff;
    u_bvag_far_side.drive(p, 1'b0);
    w(3);
    apb(1'b1, bvag_pkg::OFS_CONV_MODE, 32'hff);
    apb(1'b1, bvag_pkg::OFS_CONV_MODE, 32'h00);
    w(2);
    chk("serial", 32'h5, {plane1_high_serial, plane0_high_serial, plane1_low_serial,
      plane0_low_serial});
    p.plane_bytes = 32'h0;
    u_bvag_far_side.drive(p, 1'b0);
    w(3);
    apb(1'b1, bvag_pkg::OFS_CONV_MODE, 32'h03);
    apb(1'b1, bvag_pkg::OFS_CONV_MODE, 32'h00);
    w(2);
    chk("serial", 32'h4, {plane1_high_serial, plane0_high_serial, plane1_low_serial,
      plane0_low_serial});
    apb(1'b1, bvag_pkg::OFS_CONV_MODE, 32'h10);
    w(10);
    chk("serial", 32'h0, {plane1_high_serial, plane0_high_serial, plane1_low_serial,
      plane0_low_serial});
    apb(1'b0, 8'h40, 32'h0);
    chk("pslverr", 32'h1, slv);
    chk("prdata", 32'h0, rd);
    test_done();
  end
endmodule
`default_nettype wire
